//--- atr_pkg.sv
// Package for the attribute text display renderer.
// Assumes a 125 MHz system clock and an 8-bit Avalon-MM register and memory port.
`default_nettype none

package atr_pkg;

  // System clock and dot clock rates.
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned DOT_HZ = 7_159_090;
  // Phase accumulator step and wrap for the fractional dot-tick generator.
  localparam logic [27:0] DOT_STEP = 28'(DOT_HZ);
  localparam logic [27:0] DOT_WRAP = 28'(CLK_HZ);

  // Horizontal layout: total in dots, the rest in character cells, counted from the left border edge.
  localparam logic [8:0] H_TOTAL = 9'h1C8;
  localparam logic [5:0] H_ACT_FIRST = 6'h04;
  localparam logic [5:0] H_ACT_LAST = 6'h23;
  localparam logic [5:0] H_VIS_CHARS = 6'h28;
  localparam logic [5:0] H_SYNC_FIRST = 6'h2C;
  localparam logic [5:0] H_SYNC_LAST = 6'h2F;

  // Vertical layout in scan lines, counted from the top border edge.
  localparam logic [8:0] V_TOTAL = 9'h106;
  localparam logic [8:0] V_ACT_FIRST = 9'h010;
  localparam logic [8:0] V_ACT_END = 9'h0D0;
  localparam logic [8:0] V_VIS_END = 9'h0E0;
  localparam logic [8:0] V_SYNC_FIRST = 9'h0F0;
  localparam logic [8:0] V_SYNC_END = 9'h0F3;

  // CPU-side address pages (address bits 15:11) and the border byte address.
  localparam logic [4:0] SCREEN_REFRESH_MEMORY_PAGE = 5'h18;
  localparam logic [4:0] GLYPH_PATTERN_MEMORY_PAGE = 5'h1A;
  localparam logic [15:0] BORDER_ADDR = 16'hCA00;

  // Offsets inside the screen refresh memory.
  localparam logic [10:0] CODE_OFS = 11'h100;
  localparam logic [10:0] ATTR_OFS = 11'h500;
  localparam logic [10:0] UDP_LO_OFS = 11'h000;
  localparam logic [10:0] UDP_HI_OFS = 11'h400;

  // Attribute and code byte fields.
  localparam int unsigned ATTR_MODE_LSB = 6;
  localparam int unsigned ATTR_FG_LSB = 3;
  localparam int unsigned ATTR_BG_LSB = 0;
  localparam int unsigned CODE_HI_LSB = 3;
  localparam int unsigned CODE_LO_LSB = 0;

  // Mode field values.
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_USER = 2'h1;
  localparam logic [1:0] MODE_SEMI = 2'h2;

  // Border reset value and the read value of unmapped addresses.
  localparam logic [2:0] BORDER_RESET = 3'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // One colour: green is the most significant bit, then red, then blue.
  typedef struct packed {
    logic g;
    logic r;
    logic b;
  } atr_rgb_t;

  // Everything fetched for one character cell.
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] attr;
    logic [7:0] pat;
  } atr_cell_t;

endpackage : atr_pkg

`default_nettype wire

//--- atr_mem.sv
// Dual-port byte memory with registered read data on both ports.
// Assumes port A is the CPU side and port B the read-only video side.
`default_nettype none

module atr_mem #(
  parameter int unsigned AW = 11
) (
  // Clock and enable.
  input wire logic clk,
  input wire logic ce,
  // CPU port.
  input wire logic [AW-1:0] aAddr,
  input wire logic aWe,
  input wire logic [7:0] aWdata,
  output logic [7:0] aRdata,
  // Video port.
  input wire logic [AW-1:0] bAddr,
  output logic [7:0] bRdata
);

  // Storage array; contents are undefined until written.
  logic [7:0] mem [0:(1<<AW)-1];

  // Both ports read every enabled cycle; port A may also write.
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (aWe)
      begin
        mem[aAddr] <= aWdata;
      end
      aRdata <= mem[aAddr];
      bRdata <= mem[bAddr];
    end
  end

endmodule : atr_mem

`default_nettype wire

//--- atr_renderer.sv
// Character-cell renderer: fetches codes, attributes and patterns, draws border.
// Assumes one 125 MHz clock, synchronous inputs and an Avalon-MM master on the CPU side.
//
// Functional notes
// [R01] Attribute mode field picks normal, user, semi-graphic.
// [R02] Normal pattern address is code plus scan row.
// [R03] Pattern bits shift per dot: 1 foreground, 0 background.
// [R04] Software swaps colours for inverse; no hardware inversion.
// [R05] User mode reads patterns from screen memory.
// [R06] Sixty-four user patterns selected by display code.
// [R07] Codes 20-3F at C000, 40-5F at C400.
// [R08] Semi-graphic mode fills four solid 4x4 quarters.
// [R09] Code and attribute bits 5:3, 2:0 give quarters.
// [R10] Border surrounds active area: four columns, two rows.
// [R11] Border colour is low three written bits.
// [R12] Border register is write-only; reads give nothing.
// [R13] Colour code bits are green, red, blue.
// [R14] Dot tick at 7.15909 MHz, strobe every eight.
// [R15] Codes from C100, attributes from C500, row-major.
// [R16] Mode value 11 renders like normal mode.
`default_nettype none

module atr_renderer (
  // Clock, reset and global enable.
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Avalon-MM slave, byte address, 8-bit data.
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  // Video output.
  output atr_pkg::atr_rgb_t pixColour,
  output logic pixVisible,
  output logic hSync,
  output logic vSync,
  output logic dotStrobe,
  output logic cellStrobe
);

  // Fetch sequencer states.
  typedef enum logic [2:0] {
    F_IDLE,
    F_CODE,
    F_ATTR,
    F_PAT,
    F_LATCH
  } atr_fetch_t;

  // Dot timing state.
  logic [27:0] phase;       // Fractional dot-clock accumulator.
  logic dotTick;            // One-cycle pulse per dot.
  logic [8:0] hDot;         // Dot index within the line.
  logic [8:0] line;         // Scan line index within the frame.
  // Bus slave state.
  logic pend;               // Request accepted, answer in progress.
  logic [2:0] border;       // Border colour register.
  // Fetch state.
  atr_fetch_t fState;
  logic [4:0] fRow;         // Character row being fetched.
  logic [4:0] fCol;         // Character column being fetched.
  logic [2:0] fScan;        // Scan row inside the cell being fetched.
  atr_pkg::atr_cell_t fCell;  // Fetched cell, waiting for its slot.
  atr_pkg::atr_cell_t cur;    // Cell now being drawn; pat shifts left.
  // Memory read data.
  logic [7:0] vRdA;
  logic [7:0] vRdB;
  logic [7:0] cRdA;
  logic [7:0] cRdB;

  // Address decode of the CPU port.
  wire selVram = (avs_address[15:11] == atr_pkg::SCREEN_REFRESH_MEMORY_PAGE);
  wire selCram = (avs_address[15:11] == atr_pkg::GLYPH_PATTERN_MEMORY_PAGE);
  wire selBorder = (avs_address == atr_pkg::BORDER_ADDR);
  wire busReq = avs_read | avs_write;
  // Writes land in the cycle before waitrequest drops, while the master holds.
  wire doWrite = pend & avs_waitrequest & avs_write;
  wire vWe = doWrite & selVram;
  wire cWe = doWrite & selCram;
  // Read-back mux; the border address reads as a fixed value. [R12]
  wire [7:0] rdMux = selVram ? vRdA : (selCram ? cRdA : atr_pkg::UNMAPPED_READ);

  // Timing decode.
  wire [27:0] phaseSum = phase + atr_pkg::DOT_STEP;
  wire phaseWrap = (phaseSum >= atr_pkg::DOT_WRAP);
  wire [5:0] hChar = hDot[8:3];
  wire [2:0] dotInCell = hDot[2:0];
  wire lastDot = (hDot == atr_pkg::H_TOTAL - 9'h001);
  wire lastLine = (line == atr_pkg::V_TOTAL - 9'h001);
  wire lineAct = (line >= atr_pkg::V_ACT_FIRST) && (line < atr_pkg::V_ACT_END);
  wire lineVis = (line < atr_pkg::V_VIS_END);
  wire charAct = (hChar >= atr_pkg::H_ACT_FIRST) && (hChar <= atr_pkg::H_ACT_LAST);
  wire charVis = (hChar < atr_pkg::H_VIS_CHARS);
  wire [5:0] nextChar = hChar + 6'h01;
  wire nextAct = (nextChar >= atr_pkg::H_ACT_FIRST) && (nextChar <= atr_pkg::H_ACT_LAST);
  wire [8:0] lineRel = line - atr_pkg::V_ACT_FIRST;
  wire [5:0] colRel = nextChar - atr_pkg::H_ACT_FIRST;
  // Fetch for the next cell starts on the first dot of the current one.
  wire startFetch = dotTick && (dotInCell == 3'h0) && lineAct && nextAct;

  // Refresh memory addresses, row-major, 32 cells per row. [R15]
  wire [10:0] cellIdx = {1'b0, fRow, fCol};
  wire [10:0] codeAddr = atr_pkg::CODE_OFS + cellIdx;
  wire [10:0] attrAddr = atr_pkg::ATTR_OFS + cellIdx;
  // User patterns: bit 6 of the code picks the region, bits 4:0 the pattern. [R06] [R07]
  wire [10:0] udpBase = fCell.code[6] ? atr_pkg::UDP_HI_OFS : atr_pkg::UDP_LO_OFS;
  wire [10:0] udpAddr = udpBase | {3'h0, fCell.code[4:0], fScan};
  wire [10:0] vAddrB = (fState == F_CODE) ? codeAddr :
                       ((fState == F_ATTR) ? attrAddr : udpAddr);
  // Glyph memory address is display code with the scan row. [R02]
  wire [10:0] cAddrB = {fCell.code, fScan};
  // Mode of the cell just fetched; user mode takes the refresh-memory byte. [R05]
  wire [1:0] fMode = fCell.attr[atr_pkg::ATTR_MODE_LSB +: 2];
  wire [7:0] patSel = (fMode == atr_pkg::MODE_USER) ? vRdB : cRdB;

  // Colour of the dot being drawn.
  wire [1:0] curMode = cur.attr[atr_pkg::ATTR_MODE_LSB +: 2];
  wire [2:0] fgCol = cur.attr[atr_pkg::ATTR_FG_LSB +: 3];
  wire [2:0] bgCol = cur.attr[atr_pkg::ATTR_BG_LSB +: 3];
  // Leftmost pattern bit is drawn first; 1 is foreground, 0 background. [R03]
  wire [2:0] textCol = cur.pat[7] ? fgCol : bgCol;
  // Quarters: code gives the top pair, attribute the bottom pair. [R09]
  wire [7:0] quadSrc = line[2] ? cur.attr : cur.code;
  wire [2:0] quadCol = hDot[2] ? quadSrc[atr_pkg::CODE_HI_LSB +: 3]
                               : quadSrc[atr_pkg::CODE_LO_LSB +: 3];
  // Semi-graphic ignores the pattern; value 11 falls back to text. [R01] [R08] [R16]
  wire [2:0] cellCol = (curMode == atr_pkg::MODE_SEMI) ? quadCol : textCol;
  // Outside the active window but inside the visible frame, draw the border. [R10]
  wire [2:0] dotCol = (charAct && lineAct) ? cellCol : border;

  // Shared refresh memory holding codes, attributes and user patterns.
  atr_mem #(
    .AW(11)
  ) u_refresh (
    .clk(clk),
    .ce(ce),
    .aAddr(avs_address[10:0]),
    .aWe(vWe),
    .aWdata(avs_writedata),
    .aRdata(vRdA),
    .bAddr(vAddrB),
    .bRdata(vRdB)
  );

  // Glyph pattern memory loaded by software.
  atr_mem #(
    .AW(11)
  ) u_glyph (
    .clk(clk),
    .ce(ce),
    .aAddr(avs_address[10:0]),
    .aWe(cWe),
    .aWdata(avs_writedata),
    .aRdata(cRdA),
    .bAddr(cAddrB),
    .bRdata(cRdB)
  );

  // Fractional divider producing the dot tick from the system clock. [R14]
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      phase <= 28'h0000000;
      dotTick <= 1'b0;
    end
    else if (ce)
    begin
      phase <= phaseWrap ? (phaseSum - atr_pkg::DOT_WRAP) : phaseSum;
      dotTick <= phaseWrap;
    end
  end

  // Dot and line counters; lines are grouped in eights by line[2:0]. [R14]
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      hDot <= 9'h000;
      line <= 9'h000;
    end
    else if (ce && dotTick)
    begin
      hDot <= lastDot ? 9'h000 : hDot + 9'h001;
      if (lastDot)
      begin
        line <= lastLine ? 9'h000 : line + 9'h001;
      end
    end
  end

  // Bus answer: accept, then one cycle later drop waitrequest with data.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pend <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 8'h00;
    end
    else if (ce)
    begin
      if (!pend && busReq)
      begin
        pend <= 1'b1;
      end
      else if (pend && avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= rdMux;
      end
      else if (pend)
      begin
        // The master saw the answer at this edge; get ready for the next request.
        pend <= 1'b0;
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Border colour register keeps only the low three data bits. [R11]
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      border <= atr_pkg::BORDER_RESET;
    end
    else if (ce && doWrite && selBorder)
    begin
      border <= avs_writedata[2:0];
    end
  end

  // Fetch sequencer: code, attribute, then pattern from the chosen memory.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fState <= F_IDLE;
      fRow <= 5'h00;
      fCol <= 5'h00;
      fScan <= 3'h0;
      fCell <= '0;
    end
    else if (ce)
    begin
      case (fState)
        F_IDLE:
        begin
          if (startFetch)
          begin
            fRow <= lineRel[7:3];
            fCol <= colRel[4:0];
            fScan <= lineRel[2:0];
            fState <= F_CODE;
          end
        end
        F_CODE:
        begin
          // Code address is presented; its data arrive at this edge.
          fState <= F_ATTR;
        end
        F_ATTR:
        begin
          fCell.code <= vRdB;
          fState <= F_PAT;
        end
        F_PAT:
        begin
          fCell.attr <= vRdB;
          fState <= F_LATCH;
        end
        F_LATCH:
        begin
          fCell.pat <= patSel;  // [R01] [R05]
          fState <= F_IDLE;
        end
        default:
        begin
          fState <= F_IDLE;
        end
      endcase
    end
  end

  // Cell shifter: loads on the last dot of a cell, shifts on every other dot. [R03]
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cur <= '0;
    end
    else if (ce && dotTick)
    begin
      if (dotInCell == 3'h7)
      begin
        cur <= fCell;
      end
      else
      begin
        cur.pat <= {cur.pat[6:0], 1'b0};
      end
    end
  end

  // Registered video outputs; colour, visible and syncs update once per dot, the strobes every clock. [R13] [R14]
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pixColour <= '0;
      pixVisible <= 1'b0;
      hSync <= 1'b0;
      vSync <= 1'b0;
      dotStrobe <= 1'b0;
      cellStrobe <= 1'b0;
    end
    else if (ce)
    begin
      dotStrobe <= dotTick;
      cellStrobe <= dotTick && (dotInCell == 3'h0);
      if (dotTick)
      begin
        pixVisible <= charVis && lineVis;
        pixColour <= (charVis && lineVis) ? atr_pkg::atr_rgb_t'(dotCol) : '0;
        hSync <= (hChar >= atr_pkg::H_SYNC_FIRST) && (hChar <= atr_pkg::H_SYNC_LAST);
        vSync <= (line >= atr_pkg::V_SYNC_FIRST) && (line < atr_pkg::V_SYNC_END);
      end
    end
  end

endmodule : atr_renderer

`default_nettype wire

//--- atr_renderer_checker.sv
// Concurrent checks on the ports of the character-cell renderer.
// Assumes one clock domain, a synchronous active-low reset and ce held high.
`default_nettype none

module atr_renderer_checker (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Register and memory bus.
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  input wire logic [7:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Video side.
  input wire atr_pkg::atr_rgb_t pixColour,
  input wire logic pixVisible,
  input wire logic hSync,
  input wire logic vSync,
  input wire logic dotStrobe,
  input wire logic cellStrobe
);
  // A request of either direction is standing.
  wire logic req = avs_read || avs_write;
  // The address falls in refresh or glyph memory.
  wire logic mapped = avs_address[15:11] == atr_pkg::SCREEN_REFRESH_MEMORY_PAGE
    || avs_address[15:11] == atr_pkg::GLYPH_PATTERN_MEMORY_PAGE;
  // Dots counted inside the visible span, and in the current cell with its own strobe.
  logic [8:0] visDots;
  logic [3:0] cellDots;
  logic cellSeen;

  // Helper counters; reset clears all three, leaving the visible span clears visDots only.
  always_ff @(posedge clk)
  begin
    visDots <= (!rstn || !pixVisible) ? 9'h000 : visDots + {8'h00, dotStrobe};
    cellDots <= !rstn ? 4'h0 : (cellStrobe ? 4'h1 : cellDots + {3'h0, dotStrobe});
    cellSeen <= rstn && (cellSeen || cellStrobe);
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // First cycle of a new request, idle or right after a completion.
  sequence s_req_start;
    req && avs_waitrequest && (!$past(req) || !$past(avs_waitrequest));
  endsequence
  // Two wait cycles, then the answer.
  sequence s_two_waits;
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  a_bus_two_waits: assert property (s_req_start |-> s_two_waits)
    else $error("bus answer not after two wait cycles");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_reads_zero: assert property (avs_read && !avs_waitrequest && !mapped
    |-> avs_readdata == atr_pkg::UNMAPPED_READ)
    else $error("border or unmapped read not zero");
  a_dot_tick_spacing: assert property (dotStrobe
    |=> (!dotStrobe) [*8] ##1 (!dotStrobe) [*8] ##[1:2] dotStrobe)
    else $error("dot strobes not 17 or 18 clocks apart");
  a_cell_eight_dots: assert property (cellStrobe && cellSeen |-> cellDots == 4'h8)
    else $error("cell strobe not every eight dots");
  a_vis_on_cell: assert property ($rose(pixVisible) |-> cellStrobe)
    else $error("visible span not starting on a cell");
  a_vis_width_dots: assert property ($fell(pixVisible) |-> visDots == 9'h140)
    else $error("visible span not 320 dots");
  a_pix_on_dot: assert property (!$stable(pixColour) |-> dotStrobe)
    else $error("pixel colour changed off a dot");
  a_sync_in_blank: assert property (hSync || vSync |-> !pixVisible)
    else $error("sync inside visible span");
endmodule : atr_renderer_checker

bind atr_renderer atr_renderer_checker i_chk (.clk(clk), .rstn(rstn), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pixColour(pixColour), .pixVisible(pixVisible),
  .hSync(hSync), .vSync(vSync), .dotStrobe(dotStrobe), .cellStrobe(cellStrobe));

`default_nettype wire

//--- atr_monitor.sv
// Monitor model: turns the serial pixel stream into numbered dots.
// Assumes the stream starts at the top-left border corner after reset.
`default_nettype none

module atr_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Video from the renderer.
  input wire atr_pkg::atr_rgb_t pixColour,
  input wire logic pixVisible,
  input wire logic dotStrobe,
  // One captured dot with its position.
  output logic pxValid,
  output logic [8:0] pxX,
  output logic [8:0] pxY,
  output logic [2:0] pxCode
);
  // Visible flag one clock back, to spot the start of a line.
  logic visLast;

  // Capture each visible dot; a new visible span starts a new line.
  always_ff @(posedge clk)
  begin
    visLast <= pixVisible;
    pxValid <= rstn && dotStrobe && pixVisible;
    pxCode <= {pixColour.g, pixColour.r, pixColour.b};
    if (!rstn)
    begin
      pxY <= 9'h1FF;
      pxX <= 9'h000;
    end
    else if (dotStrobe && pixVisible)
    begin
      pxX <= visLast ? pxX + 9'h001 : 9'h000;
      pxY <= visLast ? pxY : pxY + 9'h001;
    end
  end
endmodule : atr_monitor

`default_nettype wire

//--- atr_renderer_tb_top.sv
// Self-checking bench: fills memories over the bus, then checks every dot except those past the first 16 of line 0.
// Assumes the renderer, its checker and the monitor model are compiled first.
`default_nettype none

module atr_renderer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and bus drive.
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  wire logic [7:0] avs_readdata;
  wire logic avs_waitrequest, pixVisible, hSync, vSync, dotStrobe, cellStrobe;
  wire atr_pkg::atr_rgb_t pixColour;
  // Monitor outputs.
  wire logic pxValid;
  wire logic [8:0] pxX, pxY;
  wire logic [2:0] pxCode;
  // Images of refresh and glyph memory, border colour and bench state.
  logic [7:0] vImg [0:2047];
  logic [7:0] gImg [0:2047];
  logic [2:0] border = 3'h0;
  logic [31:0] seed = 32'hA691;
  int errTotal = 0;
  int nCompared = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  atr_renderer i_dut (.clk(clk), .rstn(rstn), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pixColour(pixColour), .pixVisible(pixVisible), .hSync(hSync), .vSync(vSync),
    .dotStrobe(dotStrobe), .cellStrobe(cellStrobe));
  atr_monitor i_mon (.clk(clk), .rstn(rstn), .pixColour(pixColour),
    .pixVisible(pixVisible), .dotStrobe(dotStrobe), .pxValid(pxValid), .pxX(pxX),
    .pxY(pxY), .pxCode(pxCode));

  // Next value of the pseudo-random sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Colour expected at visible dot x of visible line y.
  function automatic logic [2:0] expPix(input logic [8:0] x, input logic [8:0] y);
    logic [5:0] cx;
    logic [5:0] cy;
    logic [7:0] c;
    logic [7:0] a;
    logic [7:0] p;
    cx = x[8:3] - 6'h04;
    cy = y[8:3] - 6'h02;
    if (x < 9'h020 || x >= 9'h120 || y < 9'h010)
      return border;
    c = vImg[atr_pkg::CODE_OFS + {1'b0, cy[4:0], cx[4:0]}];
    a = vImg[atr_pkg::ATTR_OFS + {1'b0, cy[4:0], cx[4:0]}];
    if (a[7:6] == atr_pkg::MODE_SEMI)
      return y[2] ? (x[2] ? a[5:3] : a[2:0]) : (x[2] ? c[5:3] : c[2:0]);
    if (a[7:6] == atr_pkg::MODE_USER)
      p = vImg[(c[6] ? atr_pkg::UDP_HI_OFS : atr_pkg::UDP_LO_OFS) + {3'h0, c[4:0], y[2:0]}];
    else
      p = gImg[{c, y[2:0]}];
    return p[3'h7 - x[2:0]] ? a[5:3] : a[2:0];
  endfunction : expPix

  // Counts one comparison and reports a mismatch.
  task automatic check(input logic [7:0] got, input logic [7:0] ex);
    nCompared++;
    if (got !== ex)
      begin
        errTotal++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, ex);
      end
  endtask : check

  // One bus transfer; the request stands until waitrequest is seen low.
  task automatic busOp(input logic wr, input logic [15:0] adr, input logic [7:0] wd,
                       output logic [7:0] rd);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    // Only the bench's cycle ceiling ends a wait that never gets its answer.
    do
      begin
        @(posedge clk);
      end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
  endtask : busOp

  // Write a byte and keep the bench images in step.
  task automatic wr(input logic [15:0] adr, input logic [7:0] d);
    logic [7:0] q;
    busOp(1'b1, adr, d, q);
    if (adr[15:11] == atr_pkg::SCREEN_REFRESH_MEMORY_PAGE)
      vImg[adr[10:0]] = d;
    if (adr[15:11] == atr_pkg::GLYPH_PATTERN_MEMORY_PAGE)
      gImg[adr[10:0]] = d;
    if (adr == atr_pkg::BORDER_ADDR)
      border = d[2:0];
  endtask : wr

  // Read a byte and compare it with the expected value.
  task automatic rdChk(input logic [15:0] adr, input logic [7:0] ex);
    logic [7:0] q;
    busOp(1'b0, adr, 8'h00, q);
    check(q, ex);
  endtask : rdChk

  // Prints the verdict and ends the run.
  task automatic completeRun();
    if (errTotal == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : completeRun

  // Every monitored dot is compared; line 0 only for its first 16 dots, against the reset border colour.
  always @(posedge clk)
  begin
    cycles++;
    if (pxValid && pxY == 9'h000 && pxX < 9'h010)
      check({5'h00, pxCode}, {5'h00, atr_pkg::BORDER_RESET});
    else if (pxValid && pxY != 9'h000)
      check({5'h00, pxCode}, {5'h00, expPix(pxX, pxY)});
    if (cycles > 200000)
      begin
        errTotal++;
        completeRun();
      end
  end

  // Main sequence: bus corner cases, memory fill, then watch five scan rows.
  initial
  begin
    logic [7:0] c;
    logic [7:0] a;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdChk(atr_pkg::BORDER_ADDR, atr_pkg::UNMAPPED_READ);
    wr(16'h8000, 8'hA5);
    rdChk(16'h8000, atr_pkg::UNMAPPED_READ);
    for (int col = 0; col < 32; col++)
    begin
      seed = lfsr(seed);
      c = seed[7:0];
      a = {2'(col), seed[13:8]};
      if (a[7:6] == atr_pkg::MODE_USER)
        c = (col == 1) ? 8'h3F : (col == 5) ? 8'h40 : 8'h20 + {2'h0, seed[21:16]};
      if (col == 8)
        begin
          c = vImg[11'h100];
          a = {2'h0, vImg[11'h500][2:0], vImg[11'h500][5:3]};
        end
      wr(16'hC100 + 16'(col), c);
      wr(16'hC500 + 16'(col), a);
      for (int r = 0; r < 5; r++)
      begin
        seed = lfsr(seed);
        if (col != 8)
          wr({atr_pkg::GLYPH_PATTERN_MEMORY_PAGE, c, 3'(r)}, seed[7:0]);
        if (a[7:6] == atr_pkg::MODE_USER)
          wr({atr_pkg::SCREEN_REFRESH_MEMORY_PAGE, c[6], 2'h0, c[4:0], 3'(r)}, seed[23:16]);
      end
    end
    rdChk(16'hC51F, vImg[11'h51F]);
    seed = lfsr(seed);
    wr(atr_pkg::BORDER_ADDR, 8'hF9 | seed[7:0]);
    rdChk(atr_pkg::BORDER_ADDR, atr_pkg::UNMAPPED_READ);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    while (!(pxValid && pxY == 9'h015))
      @(posedge clk);
    completeRun();
  end
endmodule : atr_renderer_tb_top

`default_nettype wire
